/* logic/mpfs_top.sv */
// Purpose: Function select registers and routing for three multipurpose pins
// Assumes: Byte register port from the chip's control interface, one access per cycle
// Notes: Pin six output enable is low while driven; the other pins are inputs only
`timescale 1ns/10ps
`include "mpfs_defines.svh"
module mpfs_top (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  input wire logic mic_input_a_pin_i,
  input wire logic mic_input_b_pin_i,
  input wire logic serial_out_b_pin_i,
  output logic serial_out_b_pin_o,
  output logic serial_out_b_pin_oe_b_o,
  input wire logic serial_data_b_i,
  input wire logic clk_out_src_i,
  output logic mic_data_01_o,
  output logic mic_data_23_o,
  output logic [3:0] mute_adc_o,
  output logic [1:0] mute_dac_o,
  output logic bank_switch_o,
  output logic compress_en_o,
  output logic bypass_en_o,
  output logic vol_up_o,
  output logic vol_down_o,
  output logic [7:0] pin_four_function_select_o,
  output logic [7:0] pin_five_function_select_o,
  output logic [7:0] pin_six_function_select_o
);
  import mpfs_pkg::*;

  mpfs_state_t st;
  mpfs_state_t next_st;
  logic [4:0] pin_four_role_code;
  logic [4:0] pin_five_role_code;
  logic [4:0] pin_six_role_code;
  logic [2:0][4:0] codes;
  logic [2:0] levels;
  mpfs_ctrl_t [2:0] reqs;
  mpfs_ctrl_t merged;
  logic six_drives;

  assign pin_four_role_code = st.pin_four_function_select[`MPFS_CODE_MSB:`MPFS_CODE_LSB];
  assign pin_five_role_code = st.pin_five_function_select[`MPFS_CODE_MSB:`MPFS_CODE_LSB];
  assign pin_six_role_code = st.pin_six_function_select[`MPFS_CODE_MSB:`MPFS_CODE_LSB];
  assign codes = {pin_six_role_code, pin_five_role_code, pin_four_role_code};
  assign levels = {serial_out_b_pin_i, mic_input_b_pin_i, mic_input_a_pin_i};

  // Upper reserved bits are kept as written, since they are read/write
  always_comb
  begin
    next_st = st;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `MPFS_OFS_PIN_FOUR: next_st.pin_four_function_select = reg_wdata_i;
        `MPFS_OFS_PIN_FIVE: next_st.pin_five_function_select = reg_wdata_i;
        `MPFS_OFS_PIN_SIX: next_st.pin_six_function_select = reg_wdata_i;
        default: next_st = st;
      endcase
    end
    next_st.rd_data = 8'h00;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `MPFS_OFS_PIN_FOUR: next_st.rd_data = st.pin_four_function_select;
        `MPFS_OFS_PIN_FIVE: next_st.rd_data = st.pin_five_function_select;
        `MPFS_OFS_PIN_SIX: next_st.rd_data = st.pin_six_function_select;
        default: next_st.rd_data = 8'h00;
      endcase
    end
    if (!rst_b_i)
    begin
      next_st.pin_four_function_select = `MPFS_RST_PIN_FOUR;
      next_st.pin_five_function_select = `MPFS_RST_PIN_FIVE;
      next_st.pin_six_function_select = `MPFS_RST_PIN_SIX;
      next_st.rd_data = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    st <= next_st;
  end

  assign reg_rdata_o = st.rd_data;
  assign reg_hit_o = (reg_addr_i == `MPFS_OFS_PIN_FOUR) || (reg_addr_i == `MPFS_OFS_PIN_FIVE) ||
                     (reg_addr_i == `MPFS_OFS_PIN_SIX);
  assign pin_four_function_select_o = st.pin_four_function_select;
  assign pin_five_function_select_o = st.pin_five_function_select;
  assign pin_six_function_select_o = st.pin_six_function_select;

  // One decoder per pin; the clock-out code falls through to no request
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      mpfs_decode u_dec (
        .code_i(codes[g]),
        .level_i(levels[g]),
        .ctrl_o(reqs[g])
      );
    end
  endgenerate

  assign merged = reqs[0] | reqs[1] | reqs[2];
  assign mute_adc_o = merged.mute_adc;
  assign mute_dac_o = merged.mute_dac;
  assign bank_switch_o = merged.bank;
  assign compress_en_o = merged.compress;
  assign bypass_en_o = merged.bypass;
  assign vol_up_o = merged.vol_up;
  assign vol_down_o = merged.vol_down;

  // Mic data gated to zero unless the pin holds its primary role
  assign mic_data_01_o = (pin_four_role_code == `MPFS_CODE_PRIMARY) & mic_input_a_pin_i;
  assign mic_data_23_o = (pin_five_role_code == `MPFS_CODE_PRIMARY) & mic_input_b_pin_i;

  assign six_drives = (pin_six_role_code == `MPFS_CODE_PRIMARY) || (pin_six_role_code == `MPFS_CODE_CLK_OUT);
  assign serial_out_b_pin_oe_b_o = ~six_drives;
  assign serial_out_b_pin_o = (pin_six_role_code == `MPFS_CODE_CLK_OUT) ? clk_out_src_i :
                              ((pin_six_role_code == `MPFS_CODE_PRIMARY) & serial_data_b_i);
endmodule

/* logic/mpfs_defines.svh */
// Purpose: Constants for the multipurpose pin function select block
// Assumes: Byte-wide registers on the chip's internal control port
// Notes: Role codes are the five low bits of each register
// Function
// - Pin four selector code 00000 routes the pin to the shared mic input for channels zero and one.
// - Pin four role code sits in bits 4:0 of an 8-bit read/write register with reserved upper bits, reset 0x00.
// - Pin five selector code 00000 routes the pin to the shared mic input for channels two and three.
// - Pin five role code sits in bits 4:0 with three reserved upper bits, register reset 0x00.
// - Pin six selector code 00000 drives the second serial data output; reset selects volume down.
// - Pin six resets to 0x11 and alone accepts code 10010, which drives a clock output.
`ifndef MPFS_DEFINES_SVH
`define MPFS_DEFINES_SVH
`define MPFS_OFS_PIN_FOUR 8'h3c
`define MPFS_OFS_PIN_FIVE 8'h3d
`define MPFS_OFS_PIN_SIX 8'h3e
`define MPFS_RST_PIN_FOUR 8'h00
`define MPFS_RST_PIN_FIVE 8'h00
`define MPFS_RST_PIN_SIX 8'h11
`define MPFS_CODE_LSB 0
`define MPFS_CODE_MSB 4
`define MPFS_CODE_PRIMARY 5'h00
`define MPFS_CODE_MUTE_IN0 5'h01
`define MPFS_CODE_MUTE_IN1 5'h02
`define MPFS_CODE_MUTE_IN2 5'h03
`define MPFS_CODE_MUTE_IN3 5'h04
`define MPFS_CODE_MUTE_IN01 5'h05
`define MPFS_CODE_MUTE_IN23 5'h06
`define MPFS_CODE_MUTE_IN_ALL 5'h07
`define MPFS_CODE_MUTE_OUT0 5'h08
`define MPFS_CODE_MUTE_OUT1 5'h09
`define MPFS_CODE_MUTE_OUT_ALL 5'h0a
`define MPFS_CODE_BANK 5'h0b
`define MPFS_CODE_COMPRESS 5'h0e
`define MPFS_CODE_BYPASS 5'h0f
`define MPFS_CODE_VOL_UP 5'h10
`define MPFS_CODE_VOL_DOWN 5'h11
`define MPFS_CODE_CLK_OUT 5'h12
`endif

/* logic/mpfs_pkg.sv */
// Purpose: Types for the multipurpose pin function select block
// Assumes: Nothing
// Notes: Control vector bit order matches mpfs_ctrl_t
package mpfs_pkg;
  typedef struct packed {
    logic vol_down;
    logic vol_up;
    logic bypass;
    logic compress;
    logic bank;
    logic [1:0] mute_dac;
    logic [3:0] mute_adc;
  } mpfs_ctrl_t;
  typedef struct packed {
    logic [7:0] pin_four_function_select;
    logic [7:0] pin_five_function_select;
    logic [7:0] pin_six_function_select;
    logic [7:0] rd_data;
  } mpfs_state_t;
endpackage

/* logic/mpfs_decode.sv */
// Purpose: Decode one pin's role code and the pin level into control requests
// Assumes: Pin level already synchronous; high means asserted
// Notes: Reserved and unknown codes request nothing
`timescale 1ns/10ps
`include "mpfs_defines.svh"
module mpfs_decode (
  input wire logic [4:0] code_i,
  input wire logic level_i,
  output mpfs_pkg::mpfs_ctrl_t ctrl_o
);
  import mpfs_pkg::*;

  always_comb
  begin
    ctrl_o = '0;
    if (level_i)
    begin
      unique case (code_i)
        `MPFS_CODE_MUTE_IN0: ctrl_o.mute_adc = 4'h1;
        `MPFS_CODE_MUTE_IN1: ctrl_o.mute_adc = 4'h2;
        `MPFS_CODE_MUTE_IN2: ctrl_o.mute_adc = 4'h4;
        `MPFS_CODE_MUTE_IN3: ctrl_o.mute_adc = 4'h8;
        `MPFS_CODE_MUTE_IN01: ctrl_o.mute_adc = 4'h3;
        `MPFS_CODE_MUTE_IN23: ctrl_o.mute_adc = 4'hc;
        `MPFS_CODE_MUTE_IN_ALL: ctrl_o.mute_adc = 4'hf;
        `MPFS_CODE_MUTE_OUT0: ctrl_o.mute_dac = 2'h1;
        `MPFS_CODE_MUTE_OUT1: ctrl_o.mute_dac = 2'h2;
        `MPFS_CODE_MUTE_OUT_ALL: ctrl_o.mute_dac = 2'h3;
        `MPFS_CODE_BANK: ctrl_o.bank = 1'b1;
        `MPFS_CODE_COMPRESS: ctrl_o.compress = 1'b1;
        `MPFS_CODE_BYPASS: ctrl_o.bypass = 1'b1;
        `MPFS_CODE_VOL_UP: ctrl_o.vol_up = 1'b1;
        `MPFS_CODE_VOL_DOWN: ctrl_o.vol_down = 1'b1;
        default: ctrl_o = '0;
      endcase
    end
  end
endmodule

/* bench/mpfs_monitor.sv */
// Purpose: Port checker for mpfs_top
// Assumes: One clock domain
// Notes: Bound from the bench top
`timescale 1ns/10ps
module mpfs_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic mic_input_a_pin_i,
  input wire logic mic_data_01_o,
  input wire logic serial_out_b_pin_o,
  input wire logic serial_out_b_pin_oe_b_o,
  input wire logic serial_data_b_i,
  input wire logic clk_out_src_i,
  input wire logic [3:0] mute_adc_o,
  input wire logic [7:0] pin_four_function_select_o,
  input wire logic [7:0] pin_six_function_select_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_mic_a_pass: assert property (pin_four_function_select_o[4:0] == 5'h00 |->
    mic_data_01_o == mic_input_a_pin_i) else $error("mic a lost");
  a_six_serial: assert property (pin_six_function_select_o[4:0] == 5'h00 |->
    !serial_out_b_pin_oe_b_o && serial_out_b_pin_o == serial_data_b_i) else $error("serial lost");
  a_six_clock: assert property (pin_six_function_select_o[4:0] == 5'h12 |->
    !serial_out_b_pin_oe_b_o && serial_out_b_pin_o == clk_out_src_i) else $error("clock lost");
  a_six_release: assert property (!(pin_six_function_select_o[4:0] inside {5'h00, 5'h12}) |->
    serial_out_b_pin_oe_b_o) else $error("pin six driven");
  a_reset_load: assert property (disable iff (1'b0) !rst_b_i |=>
    pin_four_function_select_o == 8'h00 && pin_six_function_select_o == 8'h11) else $error("reset value");
  a_write_four: assert property (reg_wr_i && reg_addr_i == 8'h3c |=>
    pin_four_function_select_o == $past(reg_wdata_i)) else $error("pin four write");
  a_write_six: assert property (reg_wr_i && reg_addr_i == 8'h3e |=>
    pin_six_function_select_o == $past(reg_wdata_i)) else $error("pin six write");
  a_mute_all: assert property (pin_four_function_select_o[4:0] == 5'h07 && mic_input_a_pin_i |->
    mute_adc_o == 4'hf) else $error("mute all");
endmodule

/* bench/mpfs_pin_model.sv */
// Purpose: Buttons and shared wire on the three pins
// Assumes: Bench pushes the buttons
// Notes: Button gives way while pin six is driven
`timescale 1ns/10ps
module mpfs_pin_model (
  input wire logic [2:0] press_i,
  input wire logic drive_i,
  input wire logic drive_oe_b_i,
  output logic [2:0] pin_o
);
  assign pin_o = {drive_oe_b_i ? press_i[2] : drive_i, press_i[1:0]};
endmodule

/* bench/mpfs_top_tb.sv */
// Purpose: Register and pin tests for mpfs_top
// Assumes: Inputs move on the falling edge
// Notes: Pin four walks role codes 1 through 18
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("Error %0t got %h", $time, g); end end
module mpfs_top_tb;
  logic ref_clk_i = '0, rst_b_i = '0, reg_wr_i = '0, reg_rd_i = '0, serial_data_b_i = '0, clk_out_src_i = '0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o;
  logic [7:0] pin_four_function_select_o, pin_five_function_select_o, pin_six_function_select_o;
  logic [2:0] press = 3'h0;
  wire logic mic_input_a_pin_i, mic_input_b_pin_i, serial_out_b_pin_i;
  logic reg_hit_o, serial_out_b_pin_o, serial_out_b_pin_oe_b_o, mic_data_01_o, mic_data_23_o;
  logic bank_switch_o, compress_en_o, bypass_en_o, vol_up_o, vol_down_o;
  logic [3:0] mute_adc_o;
  logic [1:0] mute_dac_o;
  logic [10:0] ctl;
  // Code 18 is clock out, kept by pin six alone
  logic [10:0] role [19] = '{11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h003, 11'h00c, 11'h00f, 11'h010,
    11'h020, 11'h030, 11'h040, 11'h000, 11'h000, 11'h080, 11'h100, 11'h200, 11'h400, 11'h000};
  int bad_count = 0, checked = 0;
  assign ctl = {vol_down_o, vol_up_o, bypass_en_o, compress_en_o, bank_switch_o, mute_dac_o, mute_adc_o};
  mpfs_top dut_u (.*);
  mpfs_pin_model pins_u (.press_i(press), .drive_i(serial_out_b_pin_o), .drive_oe_b_i(serial_out_b_pin_oe_b_o),
    .pin_o({serial_out_b_pin_i, mic_input_b_pin_i, mic_input_a_pin_i}));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_i);
    {reg_rd_i, reg_addr_i} = {1'b1, a};
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rdata_o, e)
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
    forever #20 ref_clk_i = ~ref_clk_i;
  // Tests need about 95 cycles
  initial
  begin
    #40000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3e, 8'h11);
    // Pin six leaves reset as the volume-down button, so it must not drive
    press = 3'h4;
    #1 `CHK({ctl, serial_out_b_pin_oe_b_o}, {11'h400, 1'b1})
    $display("reset test end");
    wr(8'h3c, 8'he0);
    wr(8'h3d, 8'ha0);
    rd(8'h3c, 8'he0);
    rd(8'h3d, 8'ha0);
    press = 3'h1;
    #1 `CHK({mic_data_23_o, mic_data_01_o}, 2'h1)
    @(negedge ref_clk_i);
    press = 3'h2;
    #1 `CHK({mic_data_23_o, mic_data_01_o}, 2'h2)
    $display("mic test end");
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'h00);
    `CHK(reg_hit_o, 1'b0)
    rd(8'h3e, 8'h11);
    `CHK(reg_hit_o, 1'b1)
    $display("unmapped test end");
    serial_data_b_i = 1'b1;
    wr(8'h3e, 8'h00);
    `CHK({serial_out_b_pin_oe_b_o, serial_out_b_pin_o, serial_out_b_pin_i}, 3'h3)
    {clk_out_src_i, serial_data_b_i} = 2'h2;
    wr(8'h3e, 8'h12);
    `CHK({serial_out_b_pin_oe_b_o, serial_out_b_pin_o, serial_out_b_pin_i}, 3'h3)
    $display("pin six test end");
    wr(8'h3d, 8'h0a);
    press = 3'h2;
    #1 `CHK({ctl, mic_data_23_o}, {11'h030, 1'b0})
    $display("pin five test end");
    wr(8'h3e, 8'h00);
    press = 3'h1;
    for (int c = 1; c < 19; c++)
    begin
      wr(8'h3c, 8'(c));
      `CHK({ctl, mic_data_01_o}, {role[c], 1'b0})
      press = 3'h0;
      #1 `CHK(ctl, 11'h000)
      @(negedge ref_clk_i);
      press = 3'h1;
    end
    $display("role test end");
    @(negedge ref_clk_i);
    rst_b_i = 1'b0;
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3e, 8'h11);
    $display("mid reset test end");
    end_sim;
  end
endmodule
bind mpfs_top mpfs_monitor mon_u (.*);
